// File: tsp_timer.sv
/*
 * 16-bit timer with one-shot pulse output, software or external trigger,
 * overflow flag and capture of the count into compare_b on trigger edges.
 * Assumes APB master on pclk; pins are synchronous to pclk.
 */
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Writing soft_shot_trigger bit 6 clears the counter and starts counting.
// - With N below M output rises on compare B, falls on compare A.
// - With N above M output rises on A, falls on B; N equal M illegal.
// - Counter keeps running after the pulse; only run mode 00 stops it.
// - Counter starts at once when run mode becomes nonzero.
// - External trigger stays live in soft mode; pin must be held steady.
// - Edge select bits 4,5 pick rising, falling or both trigger edges.
// - Valid external edge clears and starts counter, pulse follows B and A.
// - Trigger edges during an active pulse do not restart it.
// - Start is unsynchronised to count clock; first match may slip one tick.
// - Compare registers are not guaranteed after stop.
// - Overflow flag sets on wraparound in all three running modes.
// - Clearing overflow flag before count 0001H is overridden, flag sets again.
// - Capture beats a coincident read of compare B; read data undefined.
// - Stopped timer ignores input pins; counter reads never capture.
// - One-shot works only in free-running or clear-on-edge modes.
// - Capture latches on rising pclk edge; match_b_irq rises on that same edge.
// - High pin after reset gives immediate rising edge once; not on restart.
module tsp_timer
	import tsp_pkg::*;
(
	input wire logic pclk,            // APB clock, 25 MHz
	input wire logic presetn,         // Async reset, active low
	input wire logic psel,            // APB select
	input wire logic penable,         // APB access phase
	input wire logic pwrite,          // APB direction
	input wire logic [7:0] paddr,     // APB byte address
	input wire logic [31:0] pwdata,   // APB write data
	output logic [31:0] prdata,       // APB read data
	output logic pready,              // APB ready
	output logic pslverr,             // APB error on address above status offset 1CH
	input wire logic ext_trigger_pin,  // External trigger input
	input wire logic second_capture_pin, // Second capture input
	output logic pulse_out_pin,       // One-shot pulse output
	output logic match_a_irq,         // Compare A match pulse
	output logic match_b_irq          // Compare B match or capture pulse
);
	// ****************************************
	// Declarations
	// ****************************************
	logic [3:0] mode_q;
	logic [7:0] capcmp_q;
	logic [7:0] outctl_q;
	logic [7:0] presc_q;
	logic [15:0] cmpa_q;
	logic [15:0] cmpb_q;
	logic [15:0] cnt_q;
	logic ovf_q;
	logic out_q;
	logic busy_q;
	logic [15:0] div_q;
	logic tick_pre_q;
	logic trig_q;
	logic trig2_q;
	logic trig_prev_q;
	logic armed_q;
	logic cap2_q;
	logic cap2_prev_q;
	logic wr_en;
	logic rd_en;
	logic run_on;
	logic tick;
	logic edge_ok;
	logic start_pulse;
	logic soft_shot;
	logic match_a;
	logic match_b;
	logic cnt_wrap;
	logic capture_b;
	logic clear_ovf;
	tsp_run_t run_mode;

	// Prescale exponent from the 2-bit select
	function automatic logic [3:0] div_exp(input logic [1:0] sel);
		unique case (sel)
			2'b00: div_exp = TSP_DIV0;
			2'b01: div_exp = TSP_DIV1;
			default: div_exp = TSP_DIV2;
		endcase
	endfunction

	// Edge qualifier for a pin sample pair
	function automatic logic edge_hit(input logic [1:0] sel, input logic now,
			input logic prev);
		unique case (sel)
			TSP_EDGE_FALL: edge_hit = prev && !now;
			TSP_EDGE_RISE: edge_hit = !prev && now;
			TSP_EDGE_BOTH: edge_hit = prev != now;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	// ****************************************
	// APB decode
	// ****************************************
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign run_mode = tsp_run_t'(mode_q[TSP_RUN_HI:TSP_RUN_LO]);
	assign run_on = run_mode != TSP_RUN_STOP;
	assign soft_shot = wr_en && (paddr == TSP_OUTCTL_OFS) && pwdata[TSP_SHOT_BIT];
	assign clear_ovf = wr_en && (paddr == TSP_MODE_OFS) && !pwdata[TSP_OVF_BIT];

	// Zero-wait slave: ready with every access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && (paddr > TSP_STATUS_OFS);
		end
	end

	// Read mux; one cycle late because prdata is registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= TSP_ZERO32;
		end else if (psel && !penable) begin
			unique case (paddr)
				TSP_MODE_OFS: prdata <= {28'h0000000, mode_q[3:1], ovf_q};
				TSP_CAPCMP_OFS: prdata <= {24'h000000, capcmp_q};
				TSP_OUTCTL_OFS: prdata <= {24'h000000, outctl_q};
				TSP_PRESC_OFS: prdata <= {24'h000000, presc_q};
				TSP_CMPA_OFS: prdata <= {16'h0000, cmpa_q};
				// Capture in this cycle wins; value is whatever stood before
				TSP_CMPB_OFS: prdata <= {16'h0000, cmpb_q};
				TSP_COUNT_OFS: prdata <= {16'h0000, cnt_q};
				TSP_STATUS_OFS: prdata <= {30'h00000000, busy_q, ovf_q};
				default: prdata <= TSP_ZERO32;
			endcase
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= 4'h0;
			capcmp_q <= 8'h00;
			outctl_q <= 8'h00;
			presc_q <= 8'h00;
		end else if (wr_en) begin
			// Run field written here starts or stops at once
			if (paddr == TSP_MODE_OFS)
				mode_q <= pwdata[3:0];
			if (paddr == TSP_CAPCMP_OFS)
				capcmp_q <= pwdata[7:0];
			// Shot bit is a strobe, never stored
			if (paddr == TSP_OUTCTL_OFS)
				outctl_q <= pwdata[7:0] & 8'hbf;
			if (paddr == TSP_PRESC_OFS)
				presc_q <= pwdata[7:0];
		end
	end

	// Compare registers; compare_b doubles as capture register
	// Values survive a stop, but software must not count on it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmpa_q <= TSP_CNT_RST;
			cmpb_q <= TSP_CNT_RST;
		end else begin
			if (wr_en && paddr == TSP_CMPA_OFS)
				cmpa_q <= pwdata[15:0];
			// Capture has priority over a software write
			if (capture_b)
				cmpb_q <= cnt_q;
			else if (wr_en && paddr == TSP_CMPB_OFS)
				cmpb_q <= pwdata[15:0];
		end
	end

	// ****************************************
	// Count clock prescaler
	// ****************************************
	// Free divider, not restarted by triggers: start skew up to one tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= TSP_CNT_RST;
			tick_pre_q <= 1'b0;
		end else begin
			div_q <= div_q + TSP_CNT_ONE;
			tick_pre_q <= (div_q & ((TSP_CNT_ONE << div_exp(presc_q[TSP_PRE_HI:TSP_PRE_LO]))
				- TSP_CNT_ONE)) == TSP_CNT_RST;
		end
	end
	assign tick = tick_pre_q && run_on;

	// ****************************************
	// Trigger pin sampling and edge detect
	// ****************************************
	// Samples keep tracking the pin once armed, even while stopped, so a
	// restart sees no stale edge; only run_on lets an edge act on the timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_q <= 1'b0;
			trig2_q <= 1'b0;
			trig_prev_q <= 1'b0;
			armed_q <= 1'b0;
			cap2_q <= 1'b0;
			cap2_prev_q <= 1'b0;
		end else if (tick_pre_q && (run_on || armed_q)) begin
			trig_q <= ext_trigger_pin;
			trig2_q <= trig_q; // two equal samples filter glitches
			cap2_q <= second_capture_pin;
			if (trig_q == trig2_q)
				trig_prev_q <= trig2_q;
			cap2_prev_q <= cap2_q;
			armed_q <= 1'b1;
		end
	end

	// Prev starts low after reset, so a high pin yields one rising edge
	assign edge_ok = run_on && tick && armed_q && (trig_q == trig2_q)
		&& edge_hit(presc_q[TSP_ES_HI:TSP_ES_LO], trig2_q, trig_prev_q);
	assign capture_b = edge_ok && capcmp_q[TSP_CAPB_BIT];

	// Edge restarts only when no pulse is active
	assign start_pulse = soft_shot && run_on
		|| edge_ok && !busy_q && (run_mode != TSP_RUN_CLRA);

	// ****************************************
	// Counter
	// ****************************************
	assign match_a = tick && cnt_q == cmpa_q;
	assign match_b = tick && cnt_q == cmpb_q;
	assign cnt_wrap = tick && cnt_q == TSP_CNT_MAX;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= TSP_CNT_RST;
		end else if (!run_on) begin
			cnt_q <= TSP_CNT_RST;
		end else if (start_pulse) begin
			cnt_q <= TSP_CNT_RST;
		end else if (match_a && run_mode == TSP_RUN_CLRA) begin
			cnt_q <= TSP_CNT_RST;
		end else if (tick) begin
			cnt_q <= cnt_q + TSP_CNT_ONE;
		end
	end

	// Overflow: set wins over clear, and re-asserts until count reaches 0001H
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_q <= 1'b0;
		end else if (cnt_wrap) begin
			ovf_q <= 1'b1;
		end else if (clear_ovf) begin
			ovf_q <= run_on && cnt_q == TSP_CNT_RST && ovf_q;
		end
	end

	// ****************************************
	// Pulse output
	// ****************************************
	// Busy from trigger until the closing match; only outside clear-on-A mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			out_q <= 1'b0;
		end else if (!run_on) begin
			busy_q <= 1'b0;
			out_q <= outctl_q[TSP_INIT_LVL_BIT];
		end else if (start_pulse && run_mode != TSP_RUN_CLRA) begin
			busy_q <= 1'b1;
			out_q <= outctl_q[TSP_INIT_LVL_BIT];
		end else if (busy_q) begin
			if (cmpb_q < cmpa_q) begin
				if (match_b)
					out_q <= !outctl_q[TSP_INIT_LVL_BIT];
				if (match_a) begin
					out_q <= outctl_q[TSP_INIT_LVL_BIT];
					busy_q <= 1'b0;
				end
			end else begin
				if (match_a)
					out_q <= !outctl_q[TSP_INIT_LVL_BIT];
				if (match_b) begin
					out_q <= outctl_q[TSP_INIT_LVL_BIT];
					busy_q <= 1'b0;
				end
			end
		end
	end

	// Registered pins and match pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_out_pin <= 1'b0;
			match_a_irq <= 1'b0;
			match_b_irq <= 1'b0;
		end else begin
			pulse_out_pin <= out_q && outctl_q[TSP_OUT_EN_BIT];
			match_a_irq <= match_a;
			match_b_irq <= match_b || capture_b;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence shot_seq;
		soft_shot && run_on;
	endsequence

	sequence edge_go_seq;
		edge_ok && !busy_q && run_mode != TSP_RUN_CLRA;
	endsequence

	soft_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		shot_seq |=> cnt_q == TSP_CNT_RST)
		else $error("soft shot did not clear counter");
	stop_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		!run_on |=> cnt_q == TSP_CNT_RST && !busy_q)
		else $error("stopped timer not cleared");
	busy_retrig_a: assert property (@(posedge pclk) disable iff (!presetn)
		busy_q && edge_ok && !soft_shot && !match_a && !match_b |=> busy_q)
		else $error("edge restarted active pulse");
	ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		cnt_wrap |=> ovf_q && cnt_q == TSP_CNT_RST)
		else $error("overflow flag not set on wrap");
	ovf_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		cnt_wrap ##1 (clear_ovf && !tick && run_on) |=> ovf_q)
		else $error("overflow clear not defeated");
	cap_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
		capture_b |=> cmpb_q == $past(cnt_q))
		else $error("capture lost to write");
	cap_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		capture_b |=> match_b_irq)
		else $error("capture irq missing");
	pin_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		!run_on |-> !edge_ok && !capture_b)
		else $error("pin acted while stopped");
	rise_b_a: assert property (@(posedge pclk) disable iff (!presetn)
		busy_q && cmpb_q < cmpa_q && match_b && !match_a && run_on && !start_pulse
		|=> out_q != outctl_q[TSP_INIT_LVL_BIT])
		else $error("pulse not raised on compare B");
	clra_none_a: assert property (@(posedge pclk) disable iff (!presetn)
		run_mode == TSP_RUN_CLRA && !busy_q |=> !busy_q)
		else $error("one-shot started in clear-on-A mode");
	edge_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		edge_go_seq |=> cnt_q == TSP_CNT_RST && busy_q)
		else $error("valid edge did not restart counter");
	run_count_a: assert property (@(posedge pclk) disable iff (!presetn)
		tick && !start_pulse && !(match_a && run_mode == TSP_RUN_CLRA)
		|=> cnt_q == $past(cnt_q) + TSP_CNT_ONE)
		else $error("running counter did not advance");
	fall_b_a: assert property (@(posedge pclk) disable iff (!presetn)
		busy_q && !(cmpb_q < cmpa_q) && match_b && !start_pulse
		|=> !busy_q && out_q == outctl_q[TSP_INIT_LVL_BIT])
		else $error("pulse not ended on compare B");
	match_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		match_a |=> match_a_irq)
		else $error("compare A match not signalled");
endmodule

`default_nettype wire

// File: tsp_pkg.sv
/*
 * Package for the 16-bit one-shot pulse timer: register offsets, field
 * positions, reset values and mode codes.
 * Assumes an APB slave with 32-bit data, one aligned word per register.
 */
package tsp_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] TSP_MODE_OFS = 8'h00;     // mode_ctrl_reg
	localparam logic [7:0] TSP_CAPCMP_OFS = 8'h04;   // capcmp_ctrl_reg
	localparam logic [7:0] TSP_OUTCTL_OFS = 8'h08;   // out_ctrl_reg
	localparam logic [7:0] TSP_PRESC_OFS = 8'h0c;    // prescale_mode_reg
	localparam logic [7:0] TSP_CMPA_OFS = 8'h10;     // compare_a
	localparam logic [7:0] TSP_CMPB_OFS = 8'h14;     // compare_b
	localparam logic [7:0] TSP_COUNT_OFS = 8'h18;    // count_reg, read only
	localparam logic [7:0] TSP_STATUS_OFS = 8'h1c;   // overflow flag, pulse state

	// ****************************************
	// Field positions
	// ****************************************
	localparam int TSP_RUN_LO = 2;        // run_mode_bit_lo
	localparam int TSP_RUN_HI = 3;        // run_mode_bit_hi
	localparam int TSP_OVF_BIT = 0;       // overflow_flag in mode and status
	localparam int TSP_SHOT_BIT = 6;      // soft_shot_trigger
	localparam int TSP_OUT_EN_BIT = 0;    // output enable
	localparam int TSP_INIT_LVL_BIT = 1;  // idle level of the output
	localparam int TSP_ES_LO = 4;         // trig_edge_sel_lo
	localparam int TSP_ES_HI = 5;         // trig_edge_sel_hi
	localparam int TSP_PRE_LO = 0;        // count clock select, 2 bits
	localparam int TSP_PRE_HI = 1;
	localparam int TSP_CAPB_BIT = 0;      // compare_b captures on trigger edge
	localparam int TSP_BUSY_BIT = 1;      // status: pulse in progress

	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic [15:0] TSP_CNT_RST = 16'h0000;
	localparam logic [15:0] TSP_CNT_ONE = 16'h0001;
	localparam logic [15:0] TSP_CNT_MAX = 16'hffff;
	localparam logic [31:0] TSP_ZERO32 = 32'h0000_0000;

	// Run mode field values
	typedef enum logic [1:0] {
		TSP_RUN_STOP = 2'b00,
		TSP_RUN_CLRA = 2'b01,
		TSP_RUN_CLRE = 2'b10,
		TSP_RUN_FREE = 2'b11
	} tsp_run_t;

	// Trigger edge select codes
	localparam logic [1:0] TSP_EDGE_FALL = 2'b00;
	localparam logic [1:0] TSP_EDGE_RISE = 2'b01;
	localparam logic [1:0] TSP_EDGE_BOTH = 2'b11;

	// Prescaler divider exponents for select codes 0..2 (3 maps to 2)
	localparam logic [3:0] TSP_DIV0 = 4'h0;
	localparam logic [3:0] TSP_DIV1 = 4'h2;
	localparam logic [3:0] TSP_DIV2 = 4'h4;
endpackage

// File: tsp_ext_model.sv
/*
 * Far-side model: drives the trigger and second capture pins and acts as
 * the load on the pulse output, measuring each pulse.
 * Assumes pclk and presetn from the bench; pins change after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module tsp_ext_model (
	input wire logic pclk,            // Bench clock
	input wire logic presetn,         // Async reset, active low
	input wire logic pulse_out_pin,   // Load side of the pulse output
	output logic ext_trigger_pin,     // Trigger drive
	output logic second_capture_pin   // Second capture drive, held low
);
	logic prev_q;
	int width_q;
	int last_width;
	int n_pulse;

	// Pins start steady and move only on command
	initial begin
		ext_trigger_pin = 1'b0;
		second_capture_pin = 1'b0;
	end

	// Hold a new level several ticks, since one sample alone is filtered out
	task drive_trig(input logic lvl);
		@(posedge pclk);
		ext_trigger_pin <= lvl;
		repeat (4) @(posedge pclk);
	endtask

	// Width of each output pulse in clock cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 1'b0;
			width_q <= 0;
			last_width <= 0;
			n_pulse <= 0;
		end else begin
			prev_q <= pulse_out_pin;
			width_q <= pulse_out_pin ? width_q + 1 : 0;
			if (prev_q && !pulse_out_pin) begin
				last_width <= width_q;
				n_pulse <= n_pulse + 1;
			end
		end
	end
endmodule

`default_nettype wire

// File: tsp_tb.sv
/*
 * Self-checking bench for the one-shot pulse timer.
 * Assumes the count clock is pclk/1 (prescale select 0) except in the
 * prescaler scenario, which selects pclk/16.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	import tsp_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic ext_trigger_pin, second_capture_pin, pulse_out_pin, match_a_irq, match_b_irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, c1;
	int n_mismatch = 0;
	int num_checks = 0;
	int n0;
	int n_irq_a = 0;
	int n_irq_b = 0;
	int ia0;
	int ib0;

	// Match pulses as an interrupt controller would count them
	always @(posedge pclk) begin
		if (match_a_irq === 1'b1)
			n_irq_a++;
		if (match_b_irq === 1'b1)
			n_irq_b++;
	end

	tsp_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_trigger_pin(ext_trigger_pin),
		.second_capture_pin(second_capture_pin), .pulse_out_pin(pulse_out_pin),
		.match_a_irq(match_a_irq), .match_b_irq(match_b_irq));
	tsp_ext_model m (.pclk(pclk), .presetn(presetn), .pulse_out_pin(pulse_out_pin),
		.ext_trigger_pin(ext_trigger_pin), .second_capture_pin(second_capture_pin));

	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task final_report;
		if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; read data and error taken at the pready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_mismatch++;
			final_report;
		end
	endtask

	// Bounded wait for the end of the next output pulse
	task wait_pulse;
		int k;
		k = 0;
		while (m.n_pulse == n0 && k < 400) begin
			@(posedge pclk);
			k++;
		end
		if (m.n_pulse == n0) begin
			n_mismatch++;
			final_report;
		end
	endtask

	// Stop first, then edge, compares, output enable and run mode
	task cfg(input tsp_run_t md, input logic [1:0] es, input logic [15:0] a,
		input logic [15:0] b);
		apb(1'b1, TSP_MODE_OFS, TSP_ZERO32);
		apb(1'b1, TSP_PRESC_OFS, {26'h0, es, 4'h0});
		apb(1'b1, TSP_CMPA_OFS, {16'h0, a});
		apb(1'b1, TSP_CMPB_OFS, {16'h0, b});
		apb(1'b1, TSP_OUTCTL_OFS, 32'h0000_0001);
		apb(1'b1, TSP_MODE_OFS, {28'h0, md, 2'b00});
		n0 = m.n_pulse;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		apb(1'b0, TSP_COUNT_OFS, TSP_ZERO32);
		chk("count idle", 32'h0, rd);
		apb(1'b0, 8'h20, TSP_ZERO32);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
	endtask

	// Soft shot between compares a and b in either order; counter must run before and after
	task t_soft(input logic [15:0] a, input logic [15:0] b);
		cfg(TSP_RUN_FREE, 2'b10, a, b);
		apb(1'b0, TSP_COUNT_OFS, TSP_ZERO32);
		c1 = rd;
		apb(1'b0, TSP_COUNT_OFS, TSP_ZERO32);
		chk("count runs", 32'h1, {31'h0, rd > c1});
		ia0 = n_irq_a;
		ib0 = n_irq_b;
		apb(1'b1, TSP_OUTCTL_OFS, 32'h0000_0041);
		apb(1'b0, TSP_COUNT_OFS, TSP_ZERO32);
		chk("count cleared", 32'h1, {31'h0, rd < 32'd8});
		wait_pulse;
		chk("soft width", (a > b) ? a - b : b - a, m.last_width);
		chk("match a irq", 32'h1, n_irq_a - ia0);
		chk("match b irq", 32'h1, n_irq_b - ib0);
		apb(1'b0, TSP_COUNT_OFS, TSP_ZERO32);
		c1 = rd;
		apb(1'b0, TSP_COUNT_OFS, TSP_ZERO32);
		chk("runs after pulse", 32'h1, {31'h0, rd > c1});
	endtask

	// Pin moved while stopped, then a transition while in clear-on-edge mode
	task t_ext(input logic [1:0] es, input logic from, input logic to, input logic hit,
		input logic retrig);
		apb(1'b1, TSP_MODE_OFS, TSP_ZERO32);
		m.drive_trig(from);
		cfg(TSP_RUN_CLRE, es, 16'd40, 16'd10);
		m.drive_trig(to);
		if (retrig) begin
			repeat (12) @(posedge pclk);
			m.drive_trig(from);
		end
		if (hit) begin
			wait_pulse;
			chk("ext width", 32'd30, m.last_width);
		end else begin
			repeat (80) @(posedge pclk);
			chk("no pulse", n0, m.n_pulse);
		end
	endtask

	// A pin edge restarts the counter in soft-trigger operation too
	task t_soft_pin;
		m.drive_trig(1'b0);
		cfg(TSP_RUN_FREE, TSP_EDGE_RISE, 16'd40, 16'd10);
		repeat (200) @(posedge pclk);
		m.drive_trig(1'b1);
		apb(1'b0, TSP_COUNT_OFS, TSP_ZERO32);
		chk("pin restart", 32'h1, {31'h0, rd < 32'd20});
	endtask

	// Stopped counter reads zero and ignores the trigger pin
	task t_stop;
		apb(1'b1, TSP_MODE_OFS, TSP_ZERO32);
		apb(1'b0, TSP_COUNT_OFS, TSP_ZERO32);
		c1 = rd;
		n0 = m.n_pulse;
		m.drive_trig(1'b0);
		m.drive_trig(1'b1);
		apb(1'b0, TSP_COUNT_OFS, TSP_ZERO32);
		chk("stopped count", {16'h0000, TSP_CNT_RST}, rd);
		chk("stopped pulses", n0, m.n_pulse);
	endtask

	// Trigger edge captures the count into compare_b and starts the shot
	task t_cap;
		apb(1'b1, TSP_MODE_OFS, TSP_ZERO32);
		apb(1'b1, TSP_CAPCMP_OFS, 32'h0000_0001);
		m.drive_trig(1'b0);
		cfg(TSP_RUN_FREE, TSP_EDGE_RISE, 16'd40, 16'd1000);
		repeat (100) @(posedge pclk);
		m.drive_trig(1'b1);
		apb(1'b0, TSP_CMPB_OFS, TSP_ZERO32);
		c1 = rd;
		chk("capture", 32'h1, {31'h0, c1 >= 32'd100 && c1 < 32'd110});
		wait_pulse;
		chk("cap width", c1 - 32'd40, m.last_width);
		apb(1'b1, TSP_CAPCMP_OFS, TSP_ZERO32);
	endtask

	// Clear-on-A wraps at compare A with no shot; then a pclk/16 count clock
	task t_pre;
		cfg(TSP_RUN_CLRA, 2'b10, 16'd40, 16'd10);
		apb(1'b1, TSP_OUTCTL_OFS, 32'h0000_0041);
		repeat (100) @(posedge pclk);
		apb(1'b0, TSP_COUNT_OFS, TSP_ZERO32);
		chk("clear on a", 32'h1, {31'h0, rd <= 32'd40});
		chk("no shot in clra", n0, m.n_pulse);
		apb(1'b1, TSP_MODE_OFS, TSP_ZERO32);
		apb(1'b1, TSP_PRESC_OFS, 32'h0000_0022);
		apb(1'b1, TSP_MODE_OFS, {28'h0, TSP_RUN_FREE, 2'b00});
		repeat (160) @(posedge pclk);
		apb(1'b0, TSP_COUNT_OFS, TSP_ZERO32);
		chk("prescaled count", 32'h1, {31'h0, rd >= 32'd9 && rd <= 32'd11});
	endtask

	// Wraparound sets the flag; a clear well after 0001H sticks
	task t_ovf;
		int k;
		k = 0;
		cfg(TSP_RUN_FREE, 2'b10, 16'd40, 16'd10);
		do begin
			apb(1'b0, TSP_STATUS_OFS, TSP_ZERO32);
			k++;
		end while (rd[TSP_OVF_BIT] !== 1'b1 && k < 23000);
		chk("overflow set", 32'h1, {31'h0, rd[TSP_OVF_BIT]});
		apb(1'b1, TSP_MODE_OFS, {28'h0, TSP_RUN_FREE, 2'b00});
		apb(1'b0, TSP_STATUS_OFS, TSP_ZERO32);
		chk("overflow cleared", 32'h0, {31'h0, rd[TSP_OVF_BIT]});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_soft(16'd40, 16'd10);
		t_soft(16'd10, 16'd30);
		t_ext(TSP_EDGE_FALL, 1'b1, 1'b0, 1'b1, 1'b0);
		t_ext(TSP_EDGE_RISE, 1'b0, 1'b1, 1'b1, 1'b0);
		t_ext(TSP_EDGE_RISE, 1'b1, 1'b0, 1'b0, 1'b0);
		t_ext(TSP_EDGE_BOTH, 1'b0, 1'b1, 1'b1, 1'b1);
		t_soft_pin;
		t_stop;
		t_cap;
		t_pre;
		t_ovf;
		final_report;
	end
endmodule

`default_nettype wire
